// ==== bsc_cfg.svh ====
// Constants for the boundary-scan chain: widths, opcodes and field layouts
`ifndef BSC_CFG_SVH
`define BSC_CFG_SVH
`define BSC_IR_W         4
`define BSC_DR_W         32
`define BSC_TAP_COUNT    3
`define BSC_BSCAN_TAPS   2
`define BSC_CHIP_TAP     2
`define BSC_OP_ACCESS    4'h0
`define BSC_OP_DEVICE_IDENTIFICATION    4'h1
`define BSC_OP_USERCODE  4'h2
`define BSC_OP_BYPASS    4'hF
`define BSC_IR_CAPTURE   4'h1
`define BSC_ID_MARK      1'b1
`define BSC_VER_W        4
`define BSC_PART_W       16
`define BSC_MFR_W        11
`define BSC_UID_W        10
`define BSC_UNUSED_W     4
`define BSC_REV_W        18
`define BSC_SEC_UID_HI   31
`define BSC_SEC_UID_LO   22
`define BSC_UNUSED_VAL   4'h0
`define BSC_VER_VAL      4'h0
`define BSC_PART_VAL     16'h0001
`define BSC_MFR_VAL      11'h001
`define BSC_REV_VAL      18'h00001
`endif

// ==== bsc_pkg.sv ====
// Types shared by the boundary-scan chain modules
`default_nettype none
`include "bsc_cfg.svh"
package bsc_pkg;
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE,
    SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } bsc_fsm_e;

  typedef struct packed {
    logic rise;
    logic fall;
    logic tms;
    logic tdi;
  } bsc_link_s;

  typedef struct packed {
    logic data;
    logic en;
  } bsc_tdo_s;

  typedef struct packed {
    bsc_fsm_e              fsm;
    logic [`BSC_IR_W-1:0]  ir;
    logic [`BSC_IR_W-1:0]  ir_sr;
    logic [`BSC_DR_W-1:0]  dr_sr;
    logic [`BSC_DR_W-1:0]  upd;
    bsc_tdo_s              tdo;
    logic                  upd_stb;
  } bsc_tap_st_s;
endpackage : bsc_pkg
`default_nettype wire

// ==== bsc_tap.sv ====
// One test access port: standard state machine, 4-bit IR, 32-bit DR
`timescale 1ns/1ns
`default_nettype none
`include "bsc_cfg.svh"
module bsc_tap
  import bsc_pkg::*;
#(
  parameter int IR_W = `BSC_IR_W,
  parameter int DR_W = `BSC_DR_W
)(
  input  wire logic            ref_clk,
  input  wire logic            rstn,
  input  wire bsc_link_s       link,
  input  wire logic [DR_W-1:0] cap_word,
  input  wire logic [DR_W-1:0] id_word,
  input  wire logic [DR_W-1:0] user_word,
  output bsc_tdo_s             tdo,
  output logic      [DR_W-1:0] upd_word,
  output logic                 upd_stb,
  output logic                 access_sel
);
  if (IR_W != `BSC_IR_W || DR_W != `BSC_DR_W)
    $error("bsc_tap: widths must match the chain constants");

  bsc_tap_st_s s;
  bsc_tap_st_s next_s;
  logic        wide_dr;

  function automatic bsc_fsm_e fsm_step(input bsc_fsm_e st, input logic tms);
    unique case (st)
      TAP_RESET: fsm_step = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE:  fsm_step = tms ? SEL_DR : TAP_IDLE;
      SEL_DR:    fsm_step = tms ? SEL_IR : CAP_DR;
      CAP_DR:    fsm_step = tms ? EX1_DR : SH_DR;
      SH_DR:     fsm_step = tms ? EX1_DR : SH_DR;
      EX1_DR:    fsm_step = tms ? UPD_DR : PAU_DR;
      PAU_DR:    fsm_step = tms ? EX2_DR : PAU_DR;
      EX2_DR:    fsm_step = tms ? UPD_DR : SH_DR;
      UPD_DR:    fsm_step = tms ? SEL_DR : TAP_IDLE;
      SEL_IR:    fsm_step = tms ? TAP_RESET : CAP_IR;
      CAP_IR:    fsm_step = tms ? EX1_IR : SH_IR;
      SH_IR:     fsm_step = tms ? EX1_IR : SH_IR;
      EX1_IR:    fsm_step = tms ? UPD_IR : PAU_IR;
      PAU_IR:    fsm_step = tms ? EX2_IR : PAU_IR;
      EX2_IR:    fsm_step = tms ? UPD_IR : SH_IR;
      UPD_IR:    fsm_step = tms ? SEL_DR : TAP_IDLE;
    endcase
  endfunction : fsm_step

  // Unknown opcodes fall back to the one-bit bypass path
  assign wide_dr = (s.ir == `BSC_OP_ACCESS) || (s.ir == `BSC_OP_DEVICE_IDENTIFICATION)
                || (s.ir == `BSC_OP_USERCODE);

  always_comb
  begin
    next_s = s;
    next_s.upd_stb = 1'b0;
    if (s.fsm == TAP_RESET)
      next_s.ir = `BSC_OP_DEVICE_IDENTIFICATION; // RL6
    if (link.rise)
    begin
      next_s.fsm = fsm_step(s.fsm, link.tms); // RL2 RL5
      if (s.fsm == CAP_IR)
        next_s.ir_sr = `BSC_IR_CAPTURE;
      if (s.fsm == SH_IR)
        next_s.ir_sr = {link.tdi, s.ir_sr[IR_W-1:1]}; // RL3
      if (s.fsm == CAP_DR)
      begin
        if (s.ir == `BSC_OP_DEVICE_IDENTIFICATION)
          next_s.dr_sr = id_word; // RL6
        else if (s.ir == `BSC_OP_USERCODE)
          next_s.dr_sr = user_word; // RL7
        else if (s.ir == `BSC_OP_ACCESS)
          next_s.dr_sr = cap_word;
        else
          next_s.dr_sr = '0;
      end
      if (s.fsm == SH_DR)
      begin
        if (wide_dr)
          next_s.dr_sr = {link.tdi, s.dr_sr[DR_W-1:1]}; // RL3
        else
          next_s.dr_sr[0] = link.tdi;
      end
    end
    // Output and update on the falling edge, as the standard expects
    if (link.fall)
    begin
      next_s.tdo.en   = (s.fsm == SH_IR) || (s.fsm == SH_DR);
      next_s.tdo.data = (s.fsm == SH_IR) ? s.ir_sr[0]
                      : (s.fsm == SH_DR) ? s.dr_sr[0] : 1'b0;
      if (s.fsm == UPD_IR)
        next_s.ir = s.ir_sr;
      if (s.fsm == UPD_DR && s.ir == `BSC_OP_ACCESS)
      begin
        next_s.upd     = s.dr_sr;
        next_s.upd_stb = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      s <= '{fsm: TAP_RESET, ir: `BSC_OP_DEVICE_IDENTIFICATION, default: '0};
    else
      s <= next_s;
  end

  assign tdo        = s.tdo;
  assign upd_word   = s.upd;
  assign upd_stb    = s.upd_stb;
  assign access_sel = (s.ir == `BSC_OP_ACCESS);
endmodule : bsc_tap
`default_nettype wire

// ==== bsc_chain.sv ====
// Boundary-scan chain top: two pin TAPs and a chip TAP reaching the tile
//
// Summary of operation
// [RL1] Chain lets a probe load code, run boundary scan, debug, reach OTP.
// [RL2] Two standard-state-machine TAPs give boundary scan of the I/O pins.
// [RL3] Each TAP has a four-bit instruction and thirty-two-bit data register.
// [RL4] A chip-level TAP is also on the chain and reaches the tile.
// [RL5] Five test clocks with mode select high return the logic to reset.
// [RL6] Identification instruction puts the 32-bit identification word on the chain.
// [RL7] Usercode instruction puts the 32-bit usercode word on the chain.
// [RL8] Usercode user field is security bits 31:22; zero when unprogrammed.
// [RL9] Identification word: version, part number, maker code, bit 0 set.
`timescale 1ns/1ns
`default_nettype none
`include "bsc_cfg.svh"
module bsc_chain
  import bsc_pkg::*;
#(
  parameter logic [`BSC_VER_W-1:0]  VERSION  = `BSC_VER_VAL,  // Arbitrary value
  parameter logic [`BSC_PART_W-1:0] PART_NUM = `BSC_PART_VAL, // Arbitrary value
  parameter logic [`BSC_MFR_W-1:0]  MAKER_ID = `BSC_MFR_VAL,  // Arbitrary value
  parameter logic [`BSC_REV_W-1:0]  SI_REV   = `BSC_REV_VAL   // Arbitrary value
)(
  input  wire logic                                   ref_clk,
  input  wire logic                                   rstn,
  input  wire logic                                   tck,
  input  wire logic                                   tms,
  input  wire logic                                   tdi,
  output logic                                        tdo,
  output logic                                        tdo_oe_n,
  input  wire logic [`BSC_BSCAN_TAPS-1:0][`BSC_DR_W-1:0] pin_sense,
  output logic      [`BSC_BSCAN_TAPS-1:0][`BSC_DR_W-1:0] pin_force,
  output logic      [`BSC_BSCAN_TAPS-1:0]             pin_force_en,
  input  wire logic [`BSC_DR_W-1:0]                   security_word,
  input  wire logic [`BSC_DR_W-1:0]                   tile_rd_word,
  output logic      [`BSC_DR_W-1:0]                   tile_wr_word,
  output logic                                        tile_wr_stb
);
  typedef struct packed {
    logic                                         tck_s1;
    logic                                         tck_s2;
    logic                                         tck_s3;
    logic                                         tms_s1;
    logic                                         tms_s2;
    logic                                         tdi_s1;
    logic                                         tdi_s2;
    logic [`BSC_BSCAN_TAPS-1:0][`BSC_DR_W-1:0]    pin_s1;
    logic [`BSC_BSCAN_TAPS-1:0][`BSC_DR_W-1:0]    pin_s2;
    logic [`BSC_BSCAN_TAPS-1:0]                   force_en;
  } bsc_top_st_s;

  bsc_top_st_s                                 s;
  bsc_top_st_s                                 next_s;
  bsc_link_s   [`BSC_TAP_COUNT-1:0]            link;
  bsc_tdo_s    [`BSC_TAP_COUNT-1:0]            tap_tdo;
  logic        [`BSC_TAP_COUNT-1:0][`BSC_DR_W-1:0] cap_word;
  logic        [`BSC_TAP_COUNT-1:0][`BSC_DR_W-1:0] upd_word;
  logic        [`BSC_TAP_COUNT-1:0]            upd_stb;
  logic        [`BSC_TAP_COUNT-1:0]            access_sel;
  logic        [`BSC_DR_W-1:0]                 id_word;
  logic        [`BSC_DR_W-1:0]                 user_word;
  logic        [`BSC_UID_W-1:0]                fused_user_identifier;
  logic                                        tck_rise;
  logic                                        tck_fall;

  // Link pins are asynchronous; two flops before anything reads them
  always_comb
  begin
    next_s          = s;
    next_s.tck_s1   = tck;
    next_s.tck_s2   = s.tck_s1;
    next_s.tck_s3   = s.tck_s2;
    next_s.tms_s1   = tms;
    next_s.tms_s2   = s.tms_s1;
    next_s.tdi_s1   = tdi;
    next_s.tdi_s2   = s.tdi_s1;
    next_s.pin_s1   = pin_sense;
    next_s.pin_s2   = s.pin_s1;
    next_s.force_en = access_sel[`BSC_BSCAN_TAPS-1:0]; // RL2
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      s <= '0;
    else
      s <= next_s;
  end

  // Edges found from the synchronised copies; period must span several clocks
  assign tck_rise = s.tck_s2 & ~s.tck_s3;
  assign tck_fall = ~s.tck_s2 & s.tck_s3;

  assign fused_user_identifier = security_word[`BSC_SEC_UID_HI:`BSC_SEC_UID_LO]; // RL8
  assign id_word   = {VERSION, PART_NUM, MAKER_ID, `BSC_ID_MARK}; // RL9
  assign user_word = {fused_user_identifier, `BSC_UNUSED_VAL, SI_REV}; // RL7

  // Capture sources: pins for the scan TAPs, tile read word for the chip TAP
  assign cap_word[0]             = s.pin_s2[0];
  assign cap_word[1]             = s.pin_s2[1];
  assign cap_word[`BSC_CHIP_TAP] = tile_rd_word; // RL4

  // Serial order: tdi, scan TAP 0, scan TAP 1, chip TAP, tdo
  genvar i;
  for (i = 0; i < `BSC_TAP_COUNT; i++)
  begin : g_tap
    assign link[i].rise = tck_rise;
    assign link[i].fall = tck_fall;
    assign link[i].tms  = s.tms_s2; // RL5
    if (i == 0)
    begin : g_head
      assign link[i].tdi = s.tdi_s2;
    end
    else
    begin : g_body
      assign link[i].tdi = tap_tdo[i-1].data; // RL1
    end

    bsc_tap #(
      .IR_W (`BSC_IR_W),
      .DR_W (`BSC_DR_W)
    ) u_tap (
      .ref_clk    (ref_clk),
      .rstn       (rstn),
      .link       (link[i]),
      .cap_word   (cap_word[i]),
      .id_word    (id_word),
      .user_word  (user_word),
      .tdo        (tap_tdo[i]),
      .upd_word   (upd_word[i]),
      .upd_stb    (upd_stb[i]),
      .access_sel (access_sel[i])
    );
  end

  // Pins forced only while the scan TAP holds the access opcode
  assign pin_force[0]  = upd_word[0];
  assign pin_force[1]  = upd_word[1];
  assign pin_force_en  = s.force_en;

  assign tile_wr_word  = upd_word[`BSC_CHIP_TAP]; // RL4
  assign tile_wr_stb   = upd_stb[`BSC_CHIP_TAP];

  assign tdo      = tap_tdo[`BSC_CHIP_TAP].data;
  assign tdo_oe_n = ~tap_tdo[`BSC_CHIP_TAP].en;
endmodule : bsc_chain
`default_nettype wire

// ==== bsc_chain_asserts.sv ====
// Port timing checks for the boundary-scan chain
`timescale 1ns/1ns
`default_nettype none
`include "bsc_cfg.svh"
module bsc_chain_asserts (
  input wire logic                                        ref_clk,
  input wire logic                                        rstn,
  input wire logic                                        tck,
  input wire logic                                        tdo,
  input wire logic                                        tdo_oe_n,
  input wire logic [`BSC_BSCAN_TAPS-1:0][`BSC_DR_W-1:0] pin_force,
  input wire logic [`BSC_BSCAN_TAPS-1:0]                pin_force_en,
  input wire logic [`BSC_DR_W-1:0]                      tile_wr_word,
  input wire logic                                        tile_wr_stb
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  property p_rst; $rose(rstn) |=> tdo_oe_n && !tile_wr_stb && pin_force_en == 2'b00; endproperty
  a_rst: assert property (p_rst) else $error("outputs left reset state early");
  property p_stb_pulse; tile_wr_stb |=> !tile_wr_stb; endproperty
  a_stb_pulse: assert property (p_stb_pulse) else $error("tile strobe too long");
  property p_word_stb; $changed(tile_wr_word) |-> tile_wr_stb || $past(tile_wr_stb); endproperty
  a_word_stb: assert property (p_word_stb) else $error("tile word moved unstrobed");
  property p_stb_low; tile_wr_stb |-> !tck && !$past(tck, 2); endproperty
  a_stb_low: assert property (p_stb_low) else $error("tile strobe off falling edge");
  property p_tdo_hold; tck && $past(tck, 4) |-> $stable(tdo); endproperty
  a_tdo_hold: assert property (p_tdo_hold) else $error("tdo moved while clock high");
  property p_oe_hold; !tck && !$past(tck, 6) |-> $stable(tdo_oe_n); endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("tdo enable moved while clock low");
  // Enable is registered on the detected falling edge, three clocks after the pin drops
  property p_oe_fall; $changed(tdo_oe_n) |-> !tck && $past(tck, 4); endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("tdo enable off falling edge");
  property p_force_hold; tck && $past(tck, 6) |-> $stable(pin_force); endproperty
  a_force_hold: assert property (p_force_hold) else $error("pin word moved clock high");
endmodule : bsc_chain_asserts
bind bsc_chain bsc_chain_asserts u_chk (.ref_clk(ref_clk), .rstn(rstn), .tck(tck), .tdo(tdo),
  .tdo_oe_n(tdo_oe_n), .pin_force(pin_force), .pin_force_en(pin_force_en),
  .tile_wr_word(tile_wr_word), .tile_wr_stb(tile_wr_stb));
`default_nettype wire

// ==== bsc_probe.sv ====
// Behavioural test probe driving the scan link
`timescale 1ns/1ns
`default_nettype none
module bsc_probe (
  input  wire logic ref_clk,
  input  wire logic tdo,
  output var logic  tck,
  output var logic  tms,
  output var logic  tdi
);
  initial {tck, tms, tdi} = 3'b010;
  task automatic wait_n(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wait_n
  // Test clock rests low between frames; tdi inverts once the sample is safe
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    wait_n(10);
    q = tdo;
    tck = 1'b1;
    wait_n(5);
    tdi = ~d;
    wait_n(5);
    tck = 1'b0;
  endtask : step
  task automatic reset5();
    logic q;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : reset5
  // From idle: shift n bits LSB first through DR or IR, then back to idle
  task automatic scan(input logic ir, input logic [95:0] din, input int n,
                      output logic [95:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir)
      step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : scan
endmodule : bsc_probe
`default_nettype wire

// ==== test_bsc_chain.sv ====
// Self-checking bench for the boundary-scan chain
`timescale 1ns/1ns
`default_nettype none
`include "bsc_cfg.svh"
module test_bsc_chain;
  localparam logic [31:0] ID = {`BSC_VER_VAL, `BSC_PART_VAL, `BSC_MFR_VAL, `BSC_ID_MARK};
  logic             ref_clk = 1'b0;
  logic             rstn = 1'b0;
  logic             tck, tms, tdi, tdo, tdo_oe_n, tile_wr_stb;
  logic [1:0][31:0] pin_sense = '0;
  logic [1:0][31:0] pin_force;
  logic [1:0]       pin_force_en;
  logic [31:0]      security_word = '0, tile_rd_word = '0, tile_wr_word, uc;
  logic [95:0]      got, din;
  int               fail_count = 0, n_tests = 0, n_stb = 0;
  always #2 ref_clk = ~ref_clk;
  always @(negedge ref_clk) if (tile_wr_stb === 1'b1) n_stb++;
  bsc_chain uut (.ref_clk(ref_clk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe_n(tdo_oe_n), .pin_sense(pin_sense), .pin_force(pin_force),
    .pin_force_en(pin_force_en), .security_word(security_word),
    .tile_rd_word(tile_rd_word), .tile_wr_word(tile_wr_word), .tile_wr_stb(tile_wr_stb));
  bsc_probe probe (.ref_clk(ref_clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
  task automatic chk(input logic [95:0] seen, input logic [95:0] exp, input string nm);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task automatic t_user();
    probe.scan(1'b1, 96'h222, 12, got);
    chk(got, 96'h111, "ir capture");
    security_word = 32'hA97F_FFFF;
    uc = {security_word[31:22], `BSC_UNUSED_VAL, `BSC_REV_VAL};
    probe.scan(1'b0, '0, 96, got);
    chk(got, {uc, uc, uc}, "usercode");
    security_word = 32'h003F_FFFF;
    probe.scan(1'b0, '0, 32, got);
    chk(got[31:22], 10'h000, "blank user id");
    $display("usercode test done");
  endtask : t_user
  task automatic t_access();
    pin_sense = {32'h1234_5678, 32'h9ABC_DEF0};
    tile_rd_word = 32'h0F1E_2D3C;
    din = {32'hA5A5_0001, 32'h5A5A_0002, 32'hC3C3_0003};
    n_stb = 0;
    probe.scan(1'b1, 96'h000, 12, got);
    probe.scan(1'b0, din, 96, got);
    chk(got, {pin_sense[0], pin_sense[1], tile_rd_word}, "capture");
    chk(tile_wr_word, din[31:0], "tile word");
    chk(n_stb, 1, "tile strobes");
    chk(pin_force, {din[63:32], din[95:64]}, "pin words");
    chk(pin_force_en, 2'b11, "pin enables");
    $display("access test done");
  endtask : t_access
  task automatic t_reset();
    probe.scan(1'b1, 96'hFFF, 12, got);
    // Three one-bit stages: captured zeros first, then the shifted-in ones
    probe.scan(1'b0, 96'h7, 6, got);
    chk(got, 96'h38, "bypass");
    chk(pin_force_en, 2'b00, "bypass enables");
    probe.scan(1'b1, 96'h000, 12, got);
    probe.reset5();
    chk(pin_force_en, 2'b00, "reset enables");
    probe.scan(1'b0, '0, 32, got);
    chk(got[31:0], ID, "id after reset");
    $display("reset test done");
  endtask : t_reset
  initial
  begin
    repeat (20) @(posedge ref_clk);
    #1 rstn = 1'b1;
    probe.reset5();
    probe.scan(1'b0, '0, 96, got);
    chk(got, {ID, ID, ID}, "device_identification");
    chk(tdo_oe_n, 1'b1, "idle enable");
    $display("device_identification test done");
    t_user();
    t_access();
    t_reset();
    end_sim();
  end
  initial
  begin
    #300000;
    fail_count++;
    $display("Error watchdog expected done seen hang");
    end_sim();
  end
endmodule : test_bsc_chain
`default_nettype wire
